//--- hw/gmp_olp_timer.sv
// Overload delay timer with two selectable durations
`timescale 1ns/1ns
module gmp_olp_timer
#(
    parameter logic [23:0] SHORT_CYC = 24'h4C4B40,
    parameter logic [23:0] LONG_CYC = 24'h895440
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Overload level and delay selection
    input wire logic level,
    input wire logic long_sel,
    // Trip level, held while overload persists past the delay
    output logic trip
);
    typedef struct packed {
        logic [23:0] cnt;
        logic trip;
    } gmp_olp_s;

    gmp_olp_s st_r;
    gmp_olp_s st_nxt;
    logic [23:0] lim;

    assign lim = long_sel ? LONG_CYC : SHORT_CYC;

    // Count only while overload is continuous; any gap restarts it
    always_comb
    begin
        st_nxt = st_r;
        if (!level)
        begin
            st_nxt.cnt = 24'h000000;
            st_nxt.trip = 1'b0;
        end
        else if (st_r.cnt >= lim - 24'h000001)
            st_nxt.trip = 1'b1;
        else
            st_nxt.cnt = st_r.cnt + 24'h000001;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign trip = st_r.trip;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    olp_delay_a: assert property ($rose(st_r.trip)
        |-> $past(st_r.cnt) >= $past(lim) - 24'h000001)
        else $error("overload tripped before its delay");
    olp_gap_a: assert property (!level |=> !st_r.trip && st_r.cnt == '0)
        else $error("overload timer kept running through a gap");
    olp_sel_a: assert property (st_r.cnt < (long_sel ? LONG_CYC : SHORT_CYC))
        else $error("overload count beyond selected delay");
endmodule // gmp_olp_timer

//--- hw/gmp_pwm_core.sv
// Current-mode PWM control core with lockout and protection sequencing
`timescale 1ns/1ns
`include "gmp_cfg.svh"
module gmp_pwm_core
    import gmp_pkg::*;
#(
    parameter logic [15:0] GREEN_PER_CYC =
        16'(`GMP_CLK_HZ / `GMP_FGREEN_HZ),
    parameter logic [23:0] OLP_SHORT_CYC =
        24'(`GMP_OLP_SHORT_MS * `GMP_CLK_KHZ),
    parameter logic [23:0] OLP_LONG_CYC =
        24'(`GMP_OLP_LONG_MS * `GMP_CLK_KHZ)
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Supply comparators
    input wire logic vcc_above_on,
    input wire logic vcc_below_off,
    input wire logic supply_overvoltage_trip,
    // Current sense comparators
    input wire logic cs_at_feedback,
    input wire logic cs_above_max,
    // Feedback node comparators
    input wire logic fb_below_off,
    input wire logic fb_above_overload,
    input wire logic fb_below_green,
    // Gate drive and interrupt
    output logic gate_drive,
    output logic irq
);
    localparam logic [15:0] NORM_PER_CYC =
        16'(`GMP_CLK_HZ / `GMP_FSW_HZ);
    localparam logic [15:0] LEB_CYC =
        16'((`GMP_LEB_NS * `GMP_CLK_MHZ + 999) / 1000);

    gmp_core_s st_r;
    gmp_core_s st_nxt;
    logic [`GMP_FL_W-1:0] fl_raw;
    logic [`GMP_FL_W-1:0] fl;
    logic olp_level;
    logic overload_trip;
    logic [15:0] per_lim;
    logic [15:0] duty_lim;
    logic blank_done;
    logic cs_end;
    logic wr_acc;
    logic [`GMP_EV_W-1:0] ev;
    logic [`GMP_EV_W-1:0] w1c;

    // Register decode, shared by read and write paths
    function automatic logic gmp_mapped(input logic [11:0] a);
        return (a == `GMP_CTRL_OFS) || (a == `GMP_STATUS_OFS)
            || (a == `GMP_MASK_OFS) || (a == `GMP_STATE_OFS);
    endfunction

    // Gather comparator flags for the synchroniser
    always_comb
    begin
        fl_raw = '0;
        fl_raw[`GMP_FL_VCC_ON] = vcc_above_on;
        fl_raw[`GMP_FL_VCC_OFF] = vcc_below_off;
        fl_raw[`GMP_FL_CS_FB] = cs_at_feedback;
        fl_raw[`GMP_FL_CS_MAX] = cs_above_max;
        fl_raw[`GMP_FL_FB_OFF] = fb_below_off;
        fl_raw[`GMP_FL_FB_OLP] = fb_above_overload;
        fl_raw[`GMP_FL_FB_GREEN] = fb_below_green;
        fl_raw[`GMP_FL_OVP] = supply_overvoltage_trip;
    end

    gmp_sync #(
        .W(`GMP_FL_W)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(fl_raw),
        .sync_out(fl)
    );

    // Overload timing only counts while the converter is switching
    assign olp_level = fl[`GMP_FL_FB_OLP] && (st_r.state == ST_RUN);

    gmp_olp_timer #(
        .SHORT_CYC(OLP_SHORT_CYC),
        .LONG_CYC(OLP_LONG_CYC)
    ) u_olp (
        .pclk(pclk),
        .presetn(presetn),
        .level(olp_level),
        .long_sel(st_r.ctrl_long),
        .trip(overload_trip)
    );

    // Period and pulse limits of the oscillator in use
    assign per_lim = st_r.green ? GREEN_PER_CYC : NORM_PER_CYC;
    assign duty_lim = gmp_duty_lim(per_lim);
    assign blank_done = st_r.on_cnt >= LEB_CYC - 16'h0001;
    assign cs_end = blank_done
        && (fl[`GMP_FL_CS_FB] || fl[`GMP_FL_CS_MAX]);
    assign wr_acc = psel && penable && st_r.pready && pwrite;

    // Next state of sequencer, pulse generator, registers and bus
    always_comb
    begin
        st_nxt = st_r;
        ev = '0;
        w1c = '0;
        // Protection sequencer, lockout has top priority
        if (fl[`GMP_FL_VCC_OFF])
            st_nxt.state = ST_LOCKOUT;
        else
        begin
            case (st_r.state)
                ST_LOCKOUT:
                    if (fl[`GMP_FL_VCC_ON] && !fl[`GMP_FL_OVP])
                        st_nxt.state = ST_RUN;
                ST_RUN:
                    if (fl[`GMP_FL_OVP])
                        st_nxt.state = ST_OVP;
                    else if (overload_trip)
                        st_nxt.state = ST_OLP;
                    else if (fl[`GMP_FL_FB_OFF])
                        st_nxt.state = ST_REMOTE_OFF;
                ST_REMOTE_OFF:
                    if (fl[`GMP_FL_OVP])
                        st_nxt.state = ST_OVP;
                    else if (!fl[`GMP_FL_FB_OFF])
                        st_nxt.state = ST_RUN;
                ST_OVP:
                    st_nxt.state = ST_OVP;
                ST_OLP:
                    st_nxt.state = ST_OLP;
                default:
                    st_nxt.state = ST_LOCKOUT;
            endcase
        end
        // Pulse generator
        if (st_nxt.state != ST_RUN)
        begin
            st_nxt.gate = 1'b0;
            st_nxt.per_cnt = 16'h0000;
            st_nxt.on_cnt = 16'h0000;
        end
        else if (st_r.state != ST_RUN
            || st_r.per_cnt == per_lim - 16'h0001)
        begin
            st_nxt.per_cnt = 16'h0000;
            st_nxt.on_cnt = 16'h0000;
            st_nxt.gate = 1'b1;
            st_nxt.green = fl[`GMP_FL_FB_GREEN];
        end
        else
        begin
            st_nxt.per_cnt = st_r.per_cnt + 16'h0001;
            if (st_r.gate)
            begin
                st_nxt.on_cnt = st_r.on_cnt + 16'h0001;
                if (cs_end || st_r.on_cnt == duty_lim - 16'h0001)
                    st_nxt.gate = 1'b0;
            end
        end
        // Events
        ev[`GMP_EV_LOCK] = (st_nxt.state == ST_LOCKOUT)
            && (st_r.state != ST_LOCKOUT);
        ev[`GMP_EV_OVP] = (st_nxt.state == ST_OVP) && (st_r.state != ST_OVP);
        ev[`GMP_EV_OLP] = (st_nxt.state == ST_OLP) && (st_r.state != ST_OLP);
        ev[`GMP_EV_ROFF] = (st_nxt.state == ST_REMOTE_OFF)
            && (st_r.state != ST_REMOTE_OFF);
        ev[`GMP_EV_CSMAX] = st_r.gate && blank_done && fl[`GMP_FL_CS_MAX];
        ev[`GMP_EV_GREEN] = st_nxt.green && !st_r.green;
        // Register writes at the access edge
        if (wr_acc)
        begin
            case (paddr)
                `GMP_CTRL_OFS:
                    st_nxt.ctrl_long = pwdata[`GMP_CTRL_LONG_BIT];
                `GMP_STATUS_OFS:
                    w1c = pwdata[`GMP_EV_W-1:0];
                `GMP_MASK_OFS:
                    st_nxt.mask = pwdata[`GMP_EV_W-1:0];
                default:
                    w1c = '0;
            endcase
        end
        // Sticky status, a new event wins over its clear
        st_nxt.status = (st_r.status & ~w1c) | ev;
        st_nxt.irq = |(st_nxt.status & st_nxt.mask);
        // APB: ready in the first access cycle, data captured at setup
        if (psel && !penable)
        begin
            st_nxt.pready = 1'b1;
            st_nxt.pslverr = !gmp_mapped(paddr);
            st_nxt.prdata = 32'h0000_0000;
            if (!pwrite)
            begin
                case (paddr)
                    `GMP_CTRL_OFS:
                        st_nxt.prdata = {31'h0, st_r.ctrl_long};
                    `GMP_STATUS_OFS:
                        st_nxt.prdata = {26'h0, st_r.status};
                    `GMP_MASK_OFS:
                        st_nxt.prdata = {26'h0, st_r.mask};
                    `GMP_STATE_OFS:
                        st_nxt.prdata = {16'h0, fl, 2'h0, overload_trip,
                            st_r.green, st_r.gate, st_r.state};
                    default:
                        st_nxt.prdata = 32'h0000_0000;
                endcase
            end
        end
        else
        begin
            st_nxt.pready = 1'b0;
            st_nxt.pslverr = 1'b0;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= '0;
            st_r.state <= ST_LOCKOUT;
            st_r.ctrl_long <= `GMP_CTRL_RST;
            st_r.mask <= `GMP_MASK_RST;
            st_r.status <= `GMP_STATUS_RST;
        end
        else
            st_r <= st_nxt;
    end

    // Outputs straight from the state register
    assign gate_drive = st_r.gate;
    assign irq = st_r.irq;
    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_turn_on;
        $rose(st_r.gate);
    endsequence

    sequence s_blank_hold;
        (st_r.gate || st_r.state != ST_RUN)[*8];
    endsequence

    lockout_start_a: assert property ((st_r.state == ST_LOCKOUT
        && fl[`GMP_FL_VCC_ON] && !fl[`GMP_FL_VCC_OFF] && !fl[`GMP_FL_OVP])
        |=> st_r.state == ST_RUN && st_r.gate)
        else $error("no start above upper supply threshold");
    lockout_enter_a: assert property (fl[`GMP_FL_VCC_OFF]
        |=> st_r.state == ST_LOCKOUT)
        else $error("no lockout below lower supply threshold");
    gate_idle_a: assert property (st_r.state != ST_RUN |-> !st_r.gate)
        else $error("gate high outside switching state");
    cs_end_a: assert property ((st_r.gate && blank_done
        && (fl[`GMP_FL_CS_FB] || fl[`GMP_FL_CS_MAX])) |=> !st_r.gate)
        else $error("pulse not ended by current sense");
    blank_early_a: assert property (s_turn_on |-> s_blank_hold)
        else $error("pulse ended during blanking");
    blank_fall_a: assert property (($fell(st_r.gate)
        && st_r.state == ST_RUN && $past(st_r.state) == ST_RUN)
        |-> $past(st_r.on_cnt) >= LEB_CYC - 16'h0001)
        else $error("pulse shorter than blanking time");
    max_duty_a: assert property (st_r.gate
        |-> st_r.on_cnt < gmp_duty_lim(per_lim))
        else $error("gate beyond maximum duty");
    period_a: assert property (st_r.per_cnt
        < (st_r.green ? GREEN_PER_CYC : NORM_PER_CYC))
        else $error("period counter beyond its oscillator period");
    green_sel_a: assert property ((st_r.state == ST_RUN
        && st_r.per_cnt == per_lim - 16'h0001 && !fl[`GMP_FL_VCC_OFF]
        && !fl[`GMP_FL_OVP] && !overload_trip && !fl[`GMP_FL_FB_OFF])
        |=> st_r.green == $past(fl[`GMP_FL_FB_GREEN]))
        else $error("green mode not taken at period start");
    remote_off_a: assert property ((st_r.state == ST_RUN
        && fl[`GMP_FL_FB_OFF]) |=> !st_r.gate)
        else $error("gate not disabled by remote off");
    remote_rel_a: assert property ((st_r.state == ST_REMOTE_OFF
        && !fl[`GMP_FL_FB_OFF] && !fl[`GMP_FL_OVP] && !fl[`GMP_FL_VCC_OFF])
        |=> st_r.state == ST_RUN)
        else $error("no resume after remote off release");
    ovp_stop_a: assert property ((fl[`GMP_FL_OVP] && !fl[`GMP_FL_VCC_OFF]
        && (st_r.state == ST_RUN || st_r.state == ST_REMOTE_OFF))
        |=> st_r.state == ST_OVP && !st_r.gate)
        else $error("over-voltage did not stop switching");
    ovp_hold_a: assert property ((st_r.state == ST_OVP
        && !fl[`GMP_FL_VCC_OFF]) |=> st_r.state == ST_OVP)
        else $error("over-voltage left without lockout cycle");
    olp_stop_a: assert property ((st_r.state == ST_RUN && overload_trip
        && !fl[`GMP_FL_OVP] && !fl[`GMP_FL_VCC_OFF])
        |=> st_r.state == ST_OLP)
        else $error("overload trip did not stop switching");
    period_on_a: assert property ((st_r.state == ST_RUN
        && st_r.per_cnt == 16'h0000) |-> st_r.gate)
        else $error("no turn-on at period start");
    irq_level_a: assert property (st_r.irq
        == |(st_r.status & st_r.mask))
        else $error("interrupt does not follow status and mask");
endmodule // gmp_pwm_core

//--- hw/gmp_sync.sv
// Three-stage synchroniser with agreement filter for comparator flags
`timescale 1ns/1ns
module gmp_sync
#(
    parameter int W = 8
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Asynchronous flags in, clean flags out
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } gmp_sync_s;

    gmp_sync_s st_r;
    gmp_sync_s st_nxt;

    // Shift chain; output bit follows only where stages two and three agree
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = async_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.q = (st_r.q & (st_r.s2 ^ st_r.s3))
            | (st_r.s2 & ~(st_r.s2 ^ st_r.s3));
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign sync_out = st_r.q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sync_agree_a: assert property (((st_r.q ^ $past(st_r.q))
        & ($past(st_r.s2) ^ $past(st_r.s3))) == '0)
        else $error("flag changed before stages agreed");
endmodule // gmp_sync

//--- shared/gmp_cfg.svh
// Offsets, field positions, reset values and timing figures of the core
`ifndef GMP_CFG_SVH
`define GMP_CFG_SVH

// Clock and switching timing
`define GMP_CLK_HZ 100000000
`define GMP_CLK_MHZ 100
`define GMP_CLK_KHZ 100000
`define GMP_FSW_HZ 65000
`define GMP_FGREEN_HZ 20000
`define GMP_LEB_NS 200
`define GMP_MAXDUTY_PCT 75
`define GMP_OLP_SHORT_MS 50
`define GMP_OLP_LONG_MS 90

// Register byte offsets
`define GMP_CTRL_OFS 12'h000
`define GMP_STATUS_OFS 12'h004
`define GMP_MASK_OFS 12'h008
`define GMP_STATE_OFS 12'h00C

// Control fields and reset values
`define GMP_CTRL_LONG_BIT 0
`define GMP_CTRL_RST 1'h0
`define GMP_MASK_RST 6'h00
`define GMP_STATUS_RST 6'h00

// Event bits of status and mask
`define GMP_EV_W 6
`define GMP_EV_LOCK 0
`define GMP_EV_OVP 1
`define GMP_EV_OLP 2
`define GMP_EV_ROFF 3
`define GMP_EV_CSMAX 4
`define GMP_EV_GREEN 5

// Comparator flag positions in the synchronised vector
`define GMP_FL_W 8
`define GMP_FL_VCC_ON 0
`define GMP_FL_VCC_OFF 1
`define GMP_FL_CS_FB 2
`define GMP_FL_CS_MAX 3
`define GMP_FL_FB_OFF 4
`define GMP_FL_FB_OLP 5
`define GMP_FL_FB_GREEN 6
`define GMP_FL_OVP 7

`endif

//--- shared/gmp_pkg.sv
// Types and helpers shared by the PWM protection core
package gmp_pkg;
`include "gmp_cfg.svh"

    typedef enum logic [2:0] {
        ST_LOCKOUT = 3'h0,
        ST_RUN = 3'h1,
        ST_REMOTE_OFF = 3'h2,
        ST_OVP = 3'h3,
        ST_OLP = 3'h4
    } gmp_state_e;

    typedef struct packed {
        gmp_state_e state;
        logic [15:0] per_cnt;
        logic [15:0] on_cnt;
        logic green;
        logic gate;
        logic ctrl_long;
        logic [`GMP_EV_W-1:0] mask;
        logic [`GMP_EV_W-1:0] status;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } gmp_core_s;

    // Longest on time allowed within a period of the given length
    function automatic logic [15:0] gmp_duty_lim(input logic [15:0] per);
        logic [31:0] p;
        p = ({16'h0000, per} * 32'(`GMP_MAXDUTY_PCT)) / 32'h0000_0064;
        return p[15:0];
    endfunction
endpackage

//--- verif/gmp_pwm_core_tb.sv
// Self-checking bench of the PWM protection core
`timescale 1ns/1ns
`include "gmp_cfg.svh"
module gmp_pwm_core_tb;
    localparam int PER = `GMP_CLK_HZ / `GMP_FSW_HZ;
    localparam int MAXON = PER * `GMP_MAXDUTY_PCT / 100;
    localparam int GPER = 200;
    localparam int GMAX = GPER * `GMP_MAXDUTY_PCT / 100;
    localparam int TURN_ON_BLANKING = `GMP_LEB_NS * `GMP_CLK_MHZ / 1000;
    localparam int OS = 100;
    localparam int OL = 180;
    localparam logic [11:0] A_CT = `GMP_CTRL_OFS;
    localparam logic [11:0] A_SS = `GMP_STATUS_OFS;
    localparam logic [11:0] A_MK = `GMP_MASK_OFS;
    localparam logic [11:0] A_ST = `GMP_STATE_OFS;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic vcc_above_on, vcc_below_off, supply_overvoltage_trip;
    logic cs_at_feedback, cs_above_max, fb_below_off;
    logic fb_above_overload, fb_below_green, gate_drive, irq;
    int spike_cyc, ramp_cyc, n_mismatch, total_checks, hi, per, k;

    // Core with shortened green period and overload delays
    gmp_pwm_core #(.GREEN_PER_CYC(16'(GPER)), .OLP_SHORT_CYC(24'(OS)),
        .OLP_LONG_CYC(24'(OL))) gmp_pwm_core_i (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .vcc_above_on(vcc_above_on),
        .vcc_below_off(vcc_below_off),
        .supply_overvoltage_trip(supply_overvoltage_trip),
        .cs_at_feedback(cs_at_feedback), .cs_above_max(cs_above_max),
        .fb_below_off(fb_below_off), .fb_above_overload(fb_above_overload),
        .fb_below_green(fb_below_green), .gate_drive(gate_drive),
        .irq(irq));

    // Switch current seen on the sense input
    gmp_sense_model gmp_sense_model_i (.pclk(pclk),
        .gate_drive(gate_drive), .spike_cyc(spike_cyc),
        .ramp_cyc(ramp_cyc), .cs_at_feedback(cs_at_feedback));

    // Verdict and end of run
    task automatic wrap_up();
        if (n_mismatch == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Compare and count
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16)
        begin
            n_mismatch++;
            wrap_up();
        end
    endtask

    // Masked register read against an expected value
    task automatic rdc(input logic [11:0] a, input logic [31:0] m,
        input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdata & m, e);
    endtask

    // Bounded wait for a gate level
    task automatic wait_gate(input logic lvl, input int lim);
        int n;
        n = 0;
        while (gate_drive !== lvl && n < lim)
        begin
            @(negedge pclk);
            n++;
        end
        if (n >= lim)
        begin
            n_mismatch++;
            wrap_up();
        end
    endtask

    // High time and rise-to-rise period of one gate pulse
    task automatic meas();
        wait_gate(1'b0, 8000);
        wait_gate(1'b1, 8000);
        hi = 0;
        while (gate_drive === 1'b1 && hi < 8000)
        begin
            @(negedge pclk);
            hi++;
        end
        per = hi;
        while (gate_drive === 1'b0 && per < 8000)
        begin
            @(negedge pclk);
            per++;
        end
        if (per >= 8000)
        begin
            n_mismatch++;
            wrap_up();
        end
    endtask

    // Gate must stay low for n cycles
    task automatic quiet(input int n);
        int c;
        c = 0;
        repeat (n)
        begin
            @(negedge pclk);
            if (gate_drive !== 1'b0)
                c++;
        end
        chk(c, 0);
    endtask

    // Free-running bench clock
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Main sequence
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        vcc_above_on = 1'b0;
        vcc_below_off = 1'b0;
        supply_overvoltage_trip = 1'b0;
        cs_above_max = 1'b0;
        fb_below_off = 1'b0;
        fb_above_overload = 1'b0;
        fb_below_green = 1'b0;
        spike_cyc = 12;
        ramp_cyc = 100000;
        n_mismatch = 0;
        total_checks = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, unmapped access, locked-out supply
        rdc(A_CT, 32'hFFFF_FFFF, 32'h0000_0000);
        rdc(A_SS, 32'hFFFF_FFFF, 32'h0000_0000);
        rdc(A_MK, 32'hFFFF_FFFF, 32'h0000_0000);
        chk(irq, 1'b0);
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk(rerr, 1'b1);
        quiet(2000);
        rdc(A_ST, 32'h7, 32'h0);
        // Start-up; turn-on spike must not cut the pulse
        @(posedge pclk);
        vcc_above_on <= 1'b1;
        wait_gate(1'b1, 40);
        meas();
        chk(per, PER);
        chk(hi, MAXON);
        ramp_cyc = 60;
        meas();
        chk(hi >= 56 && hi <= 68, 1'b1);
        ramp_cyc = 100000;
        // Current limit ends pulses right after blanking, raises irq
        @(posedge pclk);
        cs_above_max <= 1'b1;
        meas();
        chk(hi >= TURN_ON_BLANKING && hi <= TURN_ON_BLANKING + 2, 1'b1);
        rdc(A_SS, 32'h10, 32'h10);
        apb(1'b1, A_MK, 32'h10);
        repeat (2) @(negedge pclk);
        chk(irq, 1'b1);
        @(posedge pclk);
        cs_above_max <= 1'b0;
        repeat (8) @(posedge pclk);
        apb(1'b1, A_SS, 32'h10);
        repeat (2) @(negedge pclk);
        chk(irq, 1'b0);
        rdc(A_MK, 32'hFFFF_FFFF, 32'h10);
        // Green mode period and duty limit, then back to normal
        @(posedge pclk);
        fb_below_green <= 1'b1;
        meas();
        meas();
        chk(per, GPER);
        chk(hi, GMAX);
        rdc(A_ST, 32'h10, 32'h10);
        @(posedge pclk);
        fb_below_green <= 1'b0;
        meas();
        meas();
        chk(per, PER);
        // Remote off in mid-pulse, then release
        @(posedge pclk);
        fb_below_off <= 1'b1;
        wait_gate(1'b0, 8);
        quiet(2000);
        rdc(A_ST, 32'h7, 32'h2);
        @(posedge pclk);
        fb_below_off <= 1'b0;
        wait_gate(1'b1, 10);
        // Over-voltage hiccup twice, each restart through lockout
        for (k = 0; k < 2; k++)
        begin
            @(posedge pclk);
            supply_overvoltage_trip <= 1'b1;
            wait_gate(1'b0, 8);
            @(posedge pclk);
            supply_overvoltage_trip <= 1'b0;
            quiet(3000);
            rdc(A_ST, 32'h7, 32'h3);
            @(posedge pclk);
            vcc_above_on <= 1'b0;
            vcc_below_off <= 1'b1;
            repeat (8) @(posedge pclk);
            vcc_below_off <= 1'b0;
            quiet(300);
            rdc(A_ST, 32'h7, 32'h0);
            @(posedge pclk);
            vcc_above_on <= 1'b1;
            wait_gate(1'b1, 10);
        end
        meas();
        chk(per, PER);
        // A short overload excursion is ignored
        @(posedge pclk);
        fb_above_overload <= 1'b1;
        repeat (OS / 2) @(posedge pclk);
        fb_above_overload <= 1'b0;
        repeat (20) @(posedge pclk);
        rdc(A_ST, 32'h27, 32'h01);
        // Overload trip at both delay settings
        for (k = 0; k < 2; k++)
        begin
            apb(1'b1, A_CT, k);
            @(posedge pclk);
            fb_above_overload <= 1'b1;
            repeat ((k == 1 ? OL : OS) - 10) @(posedge pclk);
            rdc(A_ST, 32'h7, 32'h1);
            repeat (20) @(posedge pclk);
            rdc(A_ST, 32'h7, 32'h4);
            quiet(2000);
            @(posedge pclk);
            fb_above_overload <= 1'b0;
            vcc_above_on <= 1'b0;
            vcc_below_off <= 1'b1;
            repeat (8) @(posedge pclk);
            vcc_below_off <= 1'b0;
            vcc_above_on <= 1'b1;
            wait_gate(1'b1, 20);
        end
        rdc(A_SS, 32'h3F, 32'h2F);
        wrap_up();
    end
endmodule // gmp_pwm_core_tb

//--- verif/gmp_sense_model.sv
// Behavioural switch current and sense comparator seen by the core
`timescale 1ns/1ns
module gmp_sense_model
(
    // Clock
    input wire logic pclk,
    // Gate from the core, spike and ramp lengths in cycles
    input wire logic gate_drive,
    input wire integer spike_cyc,
    input wire integer ramp_cyc,
    // Sensed current at or above the feedback level
    output logic cs_at_feedback = 1'b0
);
    int on_cyc = 0;

    // Turn-on spike, then a ramp; the current collapses when the gate opens
    always @(posedge pclk)
    begin
        on_cyc <= gate_drive ? on_cyc + 1 : 0;
        cs_at_feedback <= gate_drive &&
            (on_cyc < spike_cyc || on_cyc + 1 >= ramp_cyc);
    end
endmodule // gmp_sense_model
